/* core/scs_defines.vh */
// constants of the sensor command and settings block
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SCS_OFS_CMD      12'h000
`define SCS_OFS_ARG0     12'h004
`define SCS_OFS_ARG1     12'h008
`define SCS_OFS_STATUS   12'h00c
`define SCS_OFS_CFG      12'h010
`define SCS_OFS_HOLD     12'h014
`define SCS_OFS_LOGIN    12'h018
`define SCS_OFS_OUTINFO  12'h01c
`define SCS_OFS_SCALE    12'h020
`define SCS_OFS_VALUE    12'h024

// ------------------------------------------------------------
// command word fields and opcodes
// ------------------------------------------------------------
`define SCS_CMD_OP_MSB   7
`define SCS_CMD_SUB_LSB  8
`define SCS_CMD_LEN_LSB  16
`define SCS_MAX_CMD_LEN  9'h0ff
`define SCS_OP_RESTORE   8'h01
`define SCS_OP_ASCALE    8'h02
`define SCS_OP_BUTTON    8'h03
`define SCS_OP_KEYLOCK   8'h04
`define SCS_OP_RATE      8'h05
`define SCS_OP_EMITTER   8'h06
`define SCS_OP_REFVAL    8'h07
`define SCS_OP_OUTSEL    8'h08
`define SCS_OP_ERRHOLD   8'h09
`define SCS_OP_OUTLIST   8'h0a
`define SCS_OP_SERSEL    8'h0b
`define SCS_OP_SEREXTRA  8'h0c

// ------------------------------------------------------------
// error codes, numeric value of the printed code
// ------------------------------------------------------------
`define SCS_E_NONE       16'h0000
`define SCS_E_DENIED     16'h00ca
`define SCS_E_UNKNOWN    16'h00d2
`define SCS_E_TOOLONG    16'h00d6
`define SCS_E_TIMEOUT    16'h00dc
`define SCS_E_RANGE      16'h00ec
`define SCS_E_ACTIVE     16'h0106
`define SCS_E_MASTER     16'h025a

// ------------------------------------------------------------
// reset and default values
// ------------------------------------------------------------
`define SCS_DEF_RATE     2'h2
`define SCS_DEF_LASER    1'h1
`define SCS_DEF_BUTTON   2'h2
`define SCS_DEF_OUTSEL   2'h1
`define SCS_DEF_SERSEL   2'h1
`define SCS_DEF_KLMODE   2'h0
`define SCS_DEF_KLMIN    6'h01
`define SCS_DAC_LOW      16'h3333
`define SCS_DAC_SPAN     40'h000000cccc
`define SCS_VAL_MAX      18'h3ffff
`define SCS_HOLD_MAX     11'h400
`define SCS_KL_MAXMIN    6'h3c

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SCS_CLK_MHZ      100
`define SCS_MASTER_TO_MS 2000
`define SCS_MINUTE_S     60
`define SCS_MASTER_TO_CYC (64'd1000 * `SCS_MASTER_TO_MS * `SCS_CLK_MHZ)
`define SCS_MINUTE_CYC   (64'd1000000 * `SCS_MINUTE_S * `SCS_CLK_MHZ)

`endif

/* core/scs_top.v */
// sensor command interpreter and settings store behind an apb slave
// Behaviour
// - restore-all erases both groups, loads standard preset and device defaults.
// - restore-measurement erases and reloads only measurement settings.
// - restore-device erases and reloads only device settings.
// - standard maps full range to 4..20 mA; two-point maps min/max distance.
// - two-point minimum above maximum is accepted, giving inverted output.
// - button does nothing, starts mastering or starts teaching per setting.
// - keylock none never locks, active locks at once, auto after minutes.
// - measurement runs at 0.25, 0.5 or 1 kHz.
// - emitter runs at full power or is switched off.
// - master makes current value equal reference, 0..2x range; cancel ends it.
// - reference value zero performs plain zeroing.
// - master waits at most 2 s for a measurement, else timeout error.
// - mastered output value is clipped to 18 bits.
// - output goes to serial link, analog output, or nowhere.
// - on failed measurement: error at once, hold forever, or hold n cycles; analog output takes the failed sample's value instead of holding.
// - output list query reports items in transmit order.
// - serial link sends distance, counter, both or nothing per selection.
// - extra selection appends the measurement counter to each value.
// - commands longer than 255 bytes are rejected with a length error.
// - writing commands need expert level, else access denied.
// - affected commands are refused while serial transmission is active.
// - out-of-range or malformed parameters get an out-of-range error.
// - unrecognised commands get an unknown-command error.
// - reference value outside valid range gets its own error.
// - standard level reads only; expert level, by password, also writes.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "scs_defines.vh"

module scs_top #(
  parameter [63:0] MASTER_TO_CYC = `SCS_MASTER_TO_CYC,
  parameter [63:0] MINUTE_CYC    = `SCS_MINUTE_CYC,
  parameter [17:0] MEAS_RANGE    = 18'h02710,
  parameter [31:0] PASSWORD      = 32'h0000a5a5
)(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        button_in,
  input  wire        meas_valid,
  input  wire        meas_ok,
  input  wire [17:0] meas_raw,
  output reg         laser_on_q,
  output reg  [1:0]  rate_sel_q,
  output reg         teach_pulse_q,
  output reg         key_locked_q,
  output reg         ser_valid_q,
  output reg         ser_err_q,
  output reg  [1:0]  ser_items_q,
  output reg  [17:0] ser_dist_q,
  output reg  [15:0] ser_cnt_q,
  output reg  [15:0] analog_code_q,
  output reg         analog_err_q
);

  // ------------------------------------------------------------
  // settings store
  // ------------------------------------------------------------
  reg [1:0]  rate_q, button_q, outsel_q, sersel_q, klmode_q, hold_mode_q;
  reg        laser_q, extra_q, two_point_q, expert_q;
  reg [5:0]  klmin_q;
  reg [10:0] hold_n_q;
  reg [17:0] scl_min_q, scl_max_q, ref_q;
  reg signed [19:0] offset_q;
  reg [15:0] err_q;
  reg        done_q, mastering_q;
  reg [63:0] mto_q;
  reg [63:0] kl_cyc_q;
  reg [5:0]  kl_min_cnt_q;
  reg [2:0]  btn_sync_q;
  reg        btn_state_q;
  reg [10:0] hold_cnt_q;
  reg [17:0] last_q;
  reg [15:0] mcount_q;
  reg        last_good_q;

  // command decode
  wire        setup    = psel & ~penable;
  wire        wr_en    = psel & penable & pwrite;
  wire        cmd_go   = wr_en & (paddr == `SCS_OFS_CMD) & ~mastering_q;
  wire [7:0]  op       = pwdata[`SCS_CMD_OP_MSB:0];
  wire [3:0]  sub      = pwdata[`SCS_CMD_SUB_LSB+3:`SCS_CMD_SUB_LSB];
  wire [8:0]  clen     = pwdata[`SCS_CMD_LEN_LSB+8:`SCS_CMD_LEN_LSB];
  reg  [31:0] arg0_q, arg1_q;
  wire        tx_active = (outsel_q == 2'h1) & ((sersel_q != 2'h0) | extra_q);
  wire [18:0] ref_lim   = {MEAS_RANGE, 1'b0};

  // ------------------------------------------------------------
  // command check: first failing test gives the code
  // ------------------------------------------------------------
  reg [15:0] chk;
  always @*
  begin
    chk = `SCS_E_NONE;
    if (clen > `SCS_MAX_CMD_LEN)
      chk = `SCS_E_TOOLONG;
    else if (op == 8'h00 || op > `SCS_OP_SEREXTRA)
      chk = `SCS_E_UNKNOWN;
    else if (op != `SCS_OP_OUTLIST && !expert_q)
      chk = `SCS_E_DENIED;
    else if (tx_active && (op == `SCS_OP_RESTORE || op == `SCS_OP_SERSEL ||
             op == `SCS_OP_SEREXTRA || op == `SCS_OP_REFVAL))
      chk = `SCS_E_ACTIVE;
    else
      case (op)
        `SCS_OP_RESTORE, `SCS_OP_BUTTON, `SCS_OP_RATE, `SCS_OP_OUTSEL:
          if (sub > 4'h2) chk = `SCS_E_RANGE;
        `SCS_OP_ASCALE:
          if (sub > 4'h1 || (sub == 4'h1 && (arg0_q > {13'h0, ref_lim} ||
              arg1_q > {13'h0, ref_lim})))
            chk = `SCS_E_RANGE;
        `SCS_OP_KEYLOCK:
          if (sub > 4'h2 || (sub == 4'h2 && (arg0_q == 32'h0 ||
              arg0_q > {26'h0, `SCS_KL_MAXMIN})))
            chk = `SCS_E_RANGE;
        `SCS_OP_EMITTER, `SCS_OP_SEREXTRA:
          if (sub > 4'h1) chk = `SCS_E_RANGE;
        `SCS_OP_REFVAL:
          if (sub > 4'h1) chk = `SCS_E_RANGE;
          else if (sub == 4'h1 && arg0_q > {13'h0, ref_lim})
            chk = `SCS_E_MASTER;
        `SCS_OP_ERRHOLD:
          if (sub > 4'h2 || (sub == 4'h2 && (arg0_q == 32'h0 ||
              arg0_q > {21'h0, `SCS_HOLD_MAX})))
            chk = `SCS_E_RANGE;
        `SCS_OP_SERSEL:
          if (sub > 4'h3) chk = `SCS_E_RANGE;
        default:
          chk = `SCS_E_NONE;
      endcase
  end

  // ------------------------------------------------------------
  // button: three-stage synchroniser, change taken when stages 2 and 3 agree
  // ------------------------------------------------------------
  wire btn_agree = (btn_sync_q[1] == btn_sync_q[2]);
  wire btn_press = btn_agree & btn_sync_q[2] & ~btn_state_q & ~key_locked_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_sync_q  <= 3'h0;
      btn_state_q <= 1'b0;
    end
    else
    begin
      btn_sync_q <= {btn_sync_q[1:0], button_in};
      if (btn_agree)
        btn_state_q <= btn_sync_q[2];
    end
  end

  // ------------------------------------------------------------
  // keylock timer, counts whole minutes from reboot
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kl_cyc_q     <= 64'h0;
      kl_min_cnt_q <= 6'h0;
      key_locked_q <= 1'b0;
    end
    else
    begin
      if (kl_min_cnt_q != `SCS_KL_MAXMIN)
      begin
        if (kl_cyc_q == MINUTE_CYC - 64'h1)
        begin
          kl_cyc_q     <= 64'h0;
          kl_min_cnt_q <= kl_min_cnt_q + 6'h1;
        end
        else
          kl_cyc_q <= kl_cyc_q + 64'h1;
      end
      case (klmode_q)
        2'h1:    key_locked_q <= 1'b1;
        2'h2:    key_locked_q <= (kl_min_cnt_q >= klmin_q);
        default: key_locked_q <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // command execution and mastering
  // ------------------------------------------------------------
  wire start_btn_master = btn_press & (button_q == 2'h1) & ~mastering_q;
  wire [19:0] raw_ext   = {2'h0, meas_raw};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_q <= `SCS_DEF_RATE;      laser_q <= `SCS_DEF_LASER;
      button_q <= `SCS_DEF_BUTTON;  outsel_q <= `SCS_DEF_OUTSEL;
      sersel_q <= `SCS_DEF_SERSEL;  extra_q <= 1'b0;
      two_point_q <= 1'b0;          hold_mode_q <= 2'h0;
      hold_n_q <= 11'h1;            scl_min_q <= 18'h0;
      scl_max_q <= 18'h0;           ref_q <= 18'h0;
      offset_q <= 20'sh0;           klmode_q <= `SCS_DEF_KLMODE;
      klmin_q <= `SCS_DEF_KLMIN;    err_q <= `SCS_E_NONE;
      done_q <= 1'b0;               mastering_q <= 1'b0;
      mto_q <= 64'h0;               expert_q <= 1'b0;
      arg0_q <= 32'h0;              arg1_q <= 32'h0;
      teach_pulse_q <= 1'b0;
    end
    else
    begin
      teach_pulse_q <= btn_press & (button_q == 2'h2);
      if (wr_en && paddr == `SCS_OFS_ARG0) arg0_q <= pwdata;
      if (wr_en && paddr == `SCS_OFS_ARG1) arg1_q <= pwdata;
      if (wr_en && paddr == `SCS_OFS_LOGIN)
        expert_q <= (pwdata == PASSWORD);
      if (start_btn_master)
      begin
        mastering_q <= 1'b1;
        mto_q       <= 64'h0;
        done_q      <= 1'b0;
      end
      else if (mastering_q)
      begin
        if (meas_valid && meas_ok)
        begin
          // ref minus raw; zero reference simply zeroes the output
          offset_q    <= $signed({2'h0, ref_q}) - $signed(raw_ext);
          mastering_q <= 1'b0;
          done_q      <= 1'b1;
        end
        else if (mto_q == MASTER_TO_CYC - 64'h1)
        begin
          mastering_q <= 1'b0;
          err_q       <= `SCS_E_TIMEOUT;
          done_q      <= 1'b1;
        end
        else
          mto_q <= mto_q + 64'h1;
      end
      else if (cmd_go)
      begin
        err_q  <= chk;
        done_q <= (chk != `SCS_E_NONE) | (op != `SCS_OP_REFVAL) | (sub != 4'h1);
        if (chk == `SCS_E_NONE)
          case (op)
            `SCS_OP_RESTORE:
            begin
              if (sub != 4'h2)
              begin
                rate_q <= `SCS_DEF_RATE;      laser_q <= `SCS_DEF_LASER;
                button_q <= `SCS_DEF_BUTTON;  outsel_q <= `SCS_DEF_OUTSEL;
                sersel_q <= `SCS_DEF_SERSEL;  extra_q <= 1'b0;
                two_point_q <= 1'b0;          hold_mode_q <= 2'h0;
                hold_n_q <= 11'h1;            offset_q <= 20'sh0;
                ref_q <= 18'h0;
              end
              if (sub != 4'h1)
              begin
                klmode_q <= `SCS_DEF_KLMODE;
                klmin_q  <= `SCS_DEF_KLMIN;
              end
            end
            `SCS_OP_ASCALE:
            begin
              two_point_q <= sub[0];
              scl_min_q   <= arg0_q[17:0];
              scl_max_q   <= arg1_q[17:0];
            end
            `SCS_OP_BUTTON:   button_q <= sub[1:0];
            `SCS_OP_KEYLOCK:
            begin
              klmode_q <= sub[1:0];
              if (sub == 4'h2) klmin_q <= arg0_q[5:0];
            end
            `SCS_OP_RATE:     rate_q <= sub[1:0];
            `SCS_OP_EMITTER:  laser_q <= ~sub[0];
            `SCS_OP_REFVAL:
              if (sub == 4'h1)
              begin
                ref_q       <= arg0_q[17:0];
                mastering_q <= 1'b1;
                mto_q       <= 64'h0;
              end
              else
                offset_q <= 20'sh0;
            `SCS_OP_OUTSEL:   outsel_q <= sub[1:0];
            `SCS_OP_ERRHOLD:
            begin
              hold_mode_q <= sub[1:0];
              if (sub == 4'h2) hold_n_q <= arg0_q[10:0];
            end
            `SCS_OP_SERSEL:   sersel_q <= sub[1:0];
            `SCS_OP_SEREXTRA: extra_q <= sub[0];
            default:          err_q <= chk;
          endcase
      end
    end
  end

  // ------------------------------------------------------------
  // measurement path: master offset, 18-bit clip, error hold
  // ------------------------------------------------------------
  wire signed [20:0] sum_v = $signed({1'b0, raw_ext}) + $signed({offset_q[19], offset_q});
  wire [17:0] val_clip = sum_v[20] ? 18'h0 :
                         (sum_v[19:18] != 2'h0) ? `SCS_VAL_MAX : sum_v[17:0];
  // a failed sample keeps the last value while the hold allows it
  wire hold_ok = last_good_q & ((hold_mode_q == 2'h1) |
                 ((hold_mode_q == 2'h2) & (hold_cnt_q < hold_n_q)));
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= 18'h0; last_good_q <= 1'b0; hold_cnt_q <= 11'h0; mcount_q <= 16'h0;
    end
    else if (meas_valid)
    begin
      mcount_q <= mcount_q + 16'h1;
      if (meas_ok)
      begin
        last_q      <= val_clip;
        last_good_q <= 1'b1;
        hold_cnt_q  <= 11'h0;
      end
      else if (hold_ok)
        hold_cnt_q <= hold_cnt_q + 11'h1;
      else
        last_good_q <= 1'b0;
    end
  end

  // analog mapping, signed span so min above max inverts the slope
  wire [17:0] a_lo = two_point_q ? scl_min_q : 18'h0;
  wire [17:0] a_hi = two_point_q ? scl_max_q : MEAS_RANGE;
  wire signed [39:0] a_num = ($signed({22'h0, val_clip}) - $signed({22'h0, a_lo})) *
                             $signed(`SCS_DAC_SPAN);
  wire signed [39:0] a_den = $signed({22'h0, a_hi}) - $signed({22'h0, a_lo});
  wire signed [39:0] a_q   = (a_den == 40'sh0) ? 40'sh0 : a_num / a_den;
  wire [15:0] a_code = a_q[39] ? `SCS_DAC_LOW :
                       (a_q > $signed(`SCS_DAC_SPAN)) ? 16'hffff :
                       (a_q[15:0] + `SCS_DAC_LOW);

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  wire fail_now = meas_valid & ~meas_ok & ~hold_ok;
  wire [17:0] out_v = meas_ok ? val_clip : last_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_valid_q <= 1'b0; ser_err_q <= 1'b0; ser_items_q <= 2'h0;
      ser_dist_q <= 18'h0; ser_cnt_q <= 16'h0; analog_code_q <= `SCS_DAC_LOW;
      analog_err_q <= 1'b0; laser_on_q <= 1'b0; rate_sel_q <= 2'h0;
    end
    else
    begin
      laser_on_q  <= laser_q;
      rate_sel_q  <= rate_q;
      // serial frame: item bit0 distance, bit1 counter (selected or appended)
      ser_valid_q <= meas_valid & tx_active;
      ser_items_q <= {sersel_q[1] | extra_q, sersel_q[0]};
      if (meas_valid)
      begin
        ser_err_q  <= fail_now;
        ser_dist_q <= fail_now ? 18'h0 : out_v;
        ser_cnt_q  <= mcount_q;
        if (outsel_q == 2'h2)
        begin
          analog_err_q  <= fail_now;
          analog_code_q <= fail_now ? 16'h0000 : a_code;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // apb read path: data latched in setup, zero-wait answer
  // ------------------------------------------------------------
  wire [7:0] outlist = (sersel_q == 2'h3 || (sersel_q == 2'h1 && extra_q)) ? 8'h21 :
                       (sersel_q == 2'h1) ? 8'h01 :
                       (sersel_q[1] || extra_q) ? 8'h02 : 8'h00;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0; pready_q <= 1'b1; pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= 1'b1;
      if (setup)
      begin
        pslverr_q <= (paddr > `SCS_OFS_VALUE) | (paddr[1:0] != 2'h0);
        case (paddr)
          `SCS_OFS_ARG0:    prdata_q <= arg0_q;
          `SCS_OFS_ARG1:    prdata_q <= arg1_q;
          `SCS_OFS_STATUS:  prdata_q <= {err_q, 14'h0, done_q, mastering_q};
          `SCS_OFS_CFG:     prdata_q <= {12'h0, extra_q, sersel_q, outsel_q, klmin_q,
                                         klmode_q, button_q, laser_q, rate_q,
                                         two_point_q, key_locked_q};
          `SCS_OFS_HOLD:    prdata_q <= {19'h0, hold_mode_q, hold_n_q};
          `SCS_OFS_LOGIN:   prdata_q <= {31'h0, expert_q};
          `SCS_OFS_OUTINFO: prdata_q <= {24'h0, outlist};
          `SCS_OFS_SCALE:   prdata_q <= {7'h0, scl_max_q[17:0], 7'h0} ^
                                        {14'h0, scl_min_q};
          `SCS_OFS_VALUE:   prdata_q <= {14'h0, last_q};
          default:          prdata_q <= 32'h0;
        endcase
      end
    end
  end

endmodule // scs_top

/* testbench/scs_meas_model.sv */
// measurement source model standing at the far side of the block
`timescale 1ns/1ns

module scs_meas_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         req,
  input  wire  [3:0]  lag,
  input  wire         ok,
  input  wire  [17:0] raw,
  output logic        meas_valid,
  output logic        meas_ok,
  output logic [17:0] meas_raw
);
  logic       pend_q;
  logic [3:0] cnt_q;
  wire        fire = pend_q && cnt_q == 4'h0;

  // one sample per request after lag cycles; idle data lines toggle so stale values never match
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q     <= 1'b0;
      cnt_q      <= 4'h0;
      meas_valid <= 1'b0;
      meas_ok    <= 1'b0;
      meas_raw   <= 18'h0;
    end
    else
    begin
      meas_valid <= fire;
      meas_ok    <= fire ? ok : ~meas_ok;
      meas_raw   <= fire ? raw : ~meas_raw;
      if (req)
      begin
        pend_q <= 1'b1;
        cnt_q  <= lag;
      end
      else if (fire)
        pend_q <= 1'b0;
      else if (pend_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // scs_meas_model

/* testbench/scs_checker.sv */
// concurrent checks on the ports of the sensor command block
`timescale 1ns/1ns

module scs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr_q,
  input wire logic        meas_valid,
  input wire logic        ser_valid_q,
  input wire logic        ser_err_q,
  input wire logic [17:0] ser_dist_q,
  input wire logic [15:0] analog_code_q,
  input wire logic        analog_err_q,
  input wire logic [1:0]  rate_sel_q,
  input wire logic        teach_pulse_q,
  input wire logic        key_locked_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rate; rate_sel_q != 2'h3; endproperty
  a_rate: assert property (p_rate) else $error("rate code unused");
  property p_teach; teach_pulse_q |-> !$past(key_locked_q); endproperty
  a_teach: assert property (p_teach) else $error("teach while locked");
  property p_ana_upd; $changed(analog_code_q) |-> $past(meas_valid); endproperty
  a_ana_upd: assert property (p_ana_upd) else $error("analog moved alone");
  property p_err_upd; $changed(ser_err_q) |-> $past(meas_valid); endproperty
  a_err_upd: assert property (p_err_upd) else $error("error flag moved alone");
  property p_ser; ser_valid_q |-> $past(meas_valid); endproperty
  a_ser: assert property (p_ser) else $error("serial without sample");
  property p_ser_err; ser_valid_q && ser_err_q |-> ser_dist_q == 18'h0; endproperty
  a_ser_err: assert property (p_ser_err) else $error("error value not zero");
  property p_ana_err; analog_err_q |-> analog_code_q == 16'h0; endproperty
  a_ana_err: assert property (p_ana_err) else $error("analog error not zero");
  property p_ana_min; !analog_err_q |-> analog_code_q >= 16'h3333; endproperty
  a_ana_min: assert property (p_ana_min) else $error("analog below 4 mA");
  property p_unmap; psel && penable && paddr > 12'h024 |-> pslverr_q; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
endmodule // scs_checker

bind scs_top scs_checker u_chk (.*);

/* testbench/testbench.sv */
// self-checking bench of the sensor command block
`timescale 1ns/1ns
`include "scs_defines.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("wrong value %0t: %h not %h", $time, a, b); end end

module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        button_in = 1'b0;
  logic        req = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic        ok = 1'b1;
  logic [17:0] raw = 18'h0;
  logic [8:0]  clen = 9'h004;
  logic [31:0] rd;
  int          fails = 0;
  int          n_compared = 0;
  wire  [31:0] prdata_q;
  wire         pready_q, pslverr_q, meas_valid, meas_ok, laser_on_q, teach_pulse_q;
  wire         key_locked_q, ser_valid_q, ser_err_q, analog_err_q;
  wire  [1:0]  rate_sel_q, ser_items_q;
  wire  [17:0] meas_raw, ser_dist_q;
  wire  [15:0] ser_cnt_q, analog_code_q;

  // short counts keep the mastering timeout and minute timer quick
  scs_top #(.MASTER_TO_CYC(64'd50), .MINUTE_CYC(64'd20)) u_dut (.*);
  scs_meas_model u_src (.*);

  always #5 pclk = ~pclk;

  // ----
  // bus and sample tasks
  // ----
  task automatic end_sim;
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_q !== 1'b1 && i < 20)
    begin
      @(posedge pclk);
      i++;
    end
    rd = prdata_q;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready_q !== 1'b1)
    begin
      fails++;
      end_sim;
    end
    @(posedge pclk);
  endtask

  // command words carry opcode, sub-option and length; status code is checked after
  task automatic cmd(input logic [7:0] op, input logic [3:0] sub, input logic [31:0] a0,
                     input logic [15:0] ec);
    apb(1'b1, `SCS_OFS_ARG0, a0);
    apb(1'b1, `SCS_OFS_CMD, {7'h00, clen, 4'h0, sub, op});
    apb(1'b0, `SCS_OFS_STATUS, 32'h0);
    `CHK(rd[31:16], ec)
  endtask

  task automatic smp(input logic g, input logic [17:0] r);
    int i;
    i = 0;
    req <= 1'b1;
    ok  <= g;
    raw <= r;
    @(posedge pclk);
    req <= 1'b0;
    while (meas_valid !== 1'b1 && i < 20)
    begin
      @(posedge pclk);
      i++;
    end
    if (meas_valid !== 1'b1)
    begin
      fails++;
      end_sim;
    end
    @(posedge pclk);
  endtask

  // press, then release the key; three sync stages put the teach pulse on the fourth edge, sampled at the fifth
  task automatic key(input logic t);
    button_in <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(teach_pulse_q, t)
    button_in <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(8'h05, 4'h1, 32'h0, `SCS_E_DENIED);
    cmd(8'h0d, 4'h0, 32'h0, `SCS_E_UNKNOWN);
    clen = 9'h100;
    cmd(8'h05, 4'h1, 32'h0, `SCS_E_TOOLONG);
    clen = 9'h004;
    apb(1'b0, 12'h028, 32'h0);
    `CHK({pslverr_q, rd}, 33'h100000000)
    apb(1'b1, `SCS_OFS_LOGIN, 32'h0000a5a5);
    apb(1'b0, `SCS_OFS_LOGIN, 32'h0);
    `CHK(rd[0], 1'b1)
    cmd(8'h0b, 4'h3, 32'h0, `SCS_E_ACTIVE);
    for (int r = 0; r < 4; r++)
    begin
      cmd(8'h05, r[3:0], 32'h0, (r < 3) ? `SCS_E_NONE : `SCS_E_RANGE);
      `CHK(rate_sel_q, (r < 3) ? r[1:0] : 2'h2)
    end
    cmd(8'h06, 4'h1, 32'h0, `SCS_E_NONE);
    `CHK(laser_on_q, 1'b0)
    cmd(8'h06, 4'h0, 32'h0, `SCS_E_NONE);
    `CHK(laser_on_q, 1'b1)
    $display("settings test done");
    smp(1'b1, 18'h00123);
    `CHK({ser_valid_q, ser_items_q, ser_dist_q}, {3'h5, 18'h00123})
    smp(1'b0, 18'h00123);
    `CHK({ser_err_q, ser_dist_q}, 19'h40000)
    `CHK(ser_cnt_q, 16'h0001)
    cmd(8'h09, 4'h2, 32'h2, `SCS_E_NONE);
    smp(1'b1, 18'h00055);
    for (int k = 0; k < 3; k++)
    begin
      smp(1'b0, 18'h00001);
      `CHK({ser_err_q, ser_dist_q}, (k < 2) ? 19'h00055 : 19'h40000)
    end
    cmd(8'h08, 4'h0, 32'h0, `SCS_E_NONE);
    cmd(8'h0b, 4'h3, 32'h0, `SCS_E_NONE);
    cmd(8'h0c, 4'h1, 32'h0, `SCS_E_NONE);
    cmd(8'h0a, 4'h0, 32'h0, `SCS_E_NONE);
    apb(1'b0, `SCS_OFS_OUTINFO, 32'h0);
    `CHK(rd, 32'h00000021)
    smp(1'b1, 18'h00007);
    `CHK(ser_valid_q, 1'b0)
    $display("output test done");
    lag <= 4'h3;
    cmd(8'h07, 4'h1, 32'h00004e21, `SCS_E_MASTER);
    cmd(8'h07, 4'h1, 32'h0, `SCS_E_NONE);
    smp(1'b1, 18'h00064);
    apb(1'b0, `SCS_OFS_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h2)
    cmd(8'h08, 4'h1, 32'h0, `SCS_E_NONE);
    smp(1'b1, 18'h00096);
    `CHK({ser_valid_q, ser_items_q, ser_dist_q}, {3'h7, 18'h00032})
    smp(1'b1, 18'h00028);
    `CHK(ser_dist_q, 18'h0)
    cmd(8'h08, 4'h0, 32'h0, `SCS_E_NONE);
    cmd(8'h07, 4'h1, 32'h0, `SCS_E_NONE);
    repeat (60) @(posedge pclk);
    apb(1'b0, `SCS_OFS_STATUS, 32'h0);
    `CHK(rd[31:16], `SCS_E_TIMEOUT)
    cmd(8'h07, 4'h0, 32'h0, `SCS_E_NONE);
    $display("mastering test done");
    cmd(8'h08, 4'h2, 32'h0, `SCS_E_NONE);
    smp(1'b1, 18'h0);
    `CHK(analog_code_q, 16'h3333)
    smp(1'b1, 18'h02710);
    `CHK(analog_code_q, 16'hffff)
    apb(1'b1, `SCS_OFS_ARG1, 32'h0);
    cmd(8'h02, 4'h1, 32'h000003e8, `SCS_E_NONE);
    smp(1'b1, 18'h003e8);
    `CHK(analog_code_q, 16'h3333)
    smp(1'b1, 18'h0);
    `CHK(analog_code_q, 16'hffff)
    cmd(8'h09, 4'h0, 32'h0, `SCS_E_NONE);
    smp(1'b0, 18'h0);
    `CHK({analog_err_q, analog_code_q}, 17'h10000)
    cmd(8'h04, 4'h1, 32'h0, `SCS_E_NONE);
    cmd(8'h01, 4'h1, 32'h0, `SCS_E_NONE);
    apb(1'b0, `SCS_OFS_CFG, 32'h0);
    `CHK(rd, 32'h000282d9)
    key(1'b0);
    cmd(8'h08, 4'h0, 32'h0, `SCS_E_NONE);
    cmd(8'h01, 4'h2, 32'h0, `SCS_E_NONE);
    `CHK(key_locked_q, 1'b0)
    key(1'b1);
    cmd(8'h01, 4'h0, 32'h0, `SCS_E_NONE);
    apb(1'b0, `SCS_OFS_CFG, 32'h0);
    `CHK(rd, 32'h00028258)
    $display("analog and restore test done");
    end_sim;
  end
endmodule // testbench
